/* File: core/ctu_pkg.sv */
package ctu_pkg;

    // ----------------------------------------
    // register offsets (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] CTU_CTRL_OFS = 8'h00;
    localparam logic [7:0] CTU_INSTR_OFS = 8'h04;
    localparam logic [7:0] CTU_OPND_OFS = 8'h08;
    localparam logic [7:0] CTU_DATA_OFS = 8'h0c;
    localparam logic [7:0] CTU_DATA_POINTER_OFS = 8'h10;
    localparam logic [7:0] CTU_PC_OFS = 8'h14;
    localparam logic [7:0] CTU_SECOND_STATUS_WORD_OFS = 8'h18;
    localparam logic [7:0] CTU_STATUS_OFS = 8'h1c;
    localparam logic [7:0] CTU_SP_OFS = 8'h20;

    // ----------------------------------------
    // field positions and reset values
    // ----------------------------------------
    localparam int CTU_CTRL_SRC = 0;
    localparam int CTU_CTRL_FRAME = 1;
    localparam int CTU_CTRL_INTEXE = 2;
    localparam int CTU_DATA_BIT = 24;
    localparam logic [2:0] CTU_CTRL_RST = 3'h4;
    localparam logic [23:0] CTU_PC_RST = 24'hff0000;
    localparam logic [7:0] CTU_SP_RST = 8'h07;
    localparam int CTU_STACK_BYTES = 256;

    // ----------------------------------------
    // state-count additions
    // ----------------------------------------
    localparam logic [4:0] CTU_TAKEN_ADD = 5'h03;
    localparam logic [4:0] CTU_ODD_ADD = 5'h01;
    localparam logic [4:0] CTU_EXT_SHORT_ADD = 5'h02;
    localparam logic [4:0] CTU_EXT_LONG_ADD = 5'h03;
    localparam logic [4:0] CTU_FRAME_ADD = 5'h05;
    localparam logic [4:0] CTU_TEST_PORT_ADD = 5'h01;
    localparam logic [4:0] CTU_TEST_PSFR_ADD = 5'h02;
    localparam logic [4:0] CTU_DEC_PORT_ADD = 5'h02;
    localparam logic [4:0] CTU_DEC_PSFR_ADD = 5'h03;
    localparam logic [4:0] CTU_CLR_PORT_ADD = 5'h03;
    localparam logic [4:0] CTU_CLR_PSFR_ADD = 5'h05;

    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [4:0] {
        CTU_NO_OPERATION = 5'h00, CTU_BRANCH_ON_BIT_SET = 5'h01,
        CTU_BRANCH_ON_BIT_CLEAR = 5'h02, CTU_BRANCH_ON_BIT_SET_THEN_CLEAR = 5'h03,
        CTU_BRANCH_ON_ACC_ZERO = 5'h04, CTU_BRANCH_ON_ACC_NONZERO = 5'h05,
        CTU_COMPARE_BRANCH_UNEQUAL = 5'h06, CTU_DECREMENT_BRANCH_NONZERO = 5'h07,
        CTU_ABSOLUTE_JUMP = 5'h08, CTU_EXTENDED_JUMP = 5'h09, CTU_LONG_JUMP = 5'h0a,
        CTU_SHORT_RELATIVE_JUMP = 5'h0b, CTU_INDIRECT_TABLE_JUMP = 5'h0c,
        CTU_ABSOLUTE_CALL = 5'h0d, CTU_EXTENDED_CALL = 5'h0e, CTU_LONG_CALL = 5'h0f,
        CTU_SUBROUTINE_RETURN = 5'h10, CTU_EXTENDED_RETURN = 5'h11,
        CTU_INTERRUPT_RETURN = 5'h12, CTU_TRAP = 5'h13
    } ctu_op_type;

    typedef enum logic [1:0] {
        CTU_OPD_MEM = 2'h0, CTU_OPD_PORT = 2'h1, CTU_OPD_PSFR = 2'h2
    } ctu_opd_type;

    typedef struct packed {
        logic ext;
        ctu_opd_type kind;
        logic [1:0] form;
        ctu_op_type op;
    } ctu_instr_type;

    typedef struct packed {
        logic [7:0] dec;
        logic [12:0] zero;
        logic clr;
        logic carry;
        logic taken;
        logic [2:0] len;
        logic [4:0] states;
    } ctu_status_type;

    typedef struct packed {
        logic [2:0] len;
        logic [4:0] states;
    } ctu_cost_type;

endpackage : ctu_pkg

/* File: core/ctu_control_transfer.sv */
`timescale 1ns/1ps
module ctu_control_transfer
    import ctu_pkg::*;
#(
    parameter logic [23:0] TRAP_VECTOR = 24'hff0080
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata
);
    import ctu_pkg::*;

    typedef enum logic [2:0] {
        CTU_ST_IDLE = 3'b001,
        CTU_ST_EXEC = 3'b010,
        CTU_ST_DONE = 3'b100
    } ctu_state_type;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [4:0] ctu_opd_add(ctu_opd_type kind, logic [4:0] port_add,
                                               logic [4:0] psfr_add);
        if (kind == CTU_OPD_PORT) begin
            return port_add;
        end
        if (kind == CTU_OPD_PSFR) begin
            return psfr_add;
        end
        return 5'h00;
    endfunction : ctu_opd_add

    // length and not-taken states per encoding
    function automatic ctu_cost_type ctu_base_cost(ctu_op_type op, logic [1:0] form, logic src);
        ctu_cost_type c;
        c = {3'h1, 5'h01};
        unique case (op)
            CTU_NO_OPERATION: c = {3'h1, 5'h01};
            CTU_BRANCH_ON_BIT_SET, CTU_BRANCH_ON_BIT_CLEAR:
                c = form[0] ? (src ? {3'h4, 5'h03} : {3'h5, 5'h04}) : {3'h3, 5'h02};
            CTU_BRANCH_ON_BIT_SET_THEN_CLEAR:
                c = form[0] ? (src ? {3'h4, 5'h06} : {3'h5, 5'h07}) : {3'h3, 5'h04};
            CTU_BRANCH_ON_ACC_ZERO, CTU_BRANCH_ON_ACC_NONZERO: c = {3'h2, 5'h02};
            CTU_COMPARE_BRANCH_UNEQUAL: begin
                unique case (form)
                    2'h2: c = src ? {3'h4, 5'h03} : {3'h3, 5'h02};
                    2'h3: c = src ? {3'h4, 5'h04} : {3'h3, 5'h03};
                    default: c = {3'h3, 5'h02};
                endcase
            end
            CTU_DECREMENT_BRANCH_NONZERO:
                c = form[0] ? {3'h3, 5'h03} : (src ? {3'h3, 5'h03} : {3'h2, 5'h02});
            CTU_ABSOLUTE_JUMP: c = {3'h2, 5'h03};
            CTU_EXTENDED_JUMP:
                c = form[0] ? (src ? {3'h2, 5'h06} : {3'h3, 5'h07}) : (src ? {3'h4, 5'h05} : {3'h5, 5'h06});
            CTU_LONG_JUMP:
                c = form[0] ? (src ? {3'h2, 5'h05} : {3'h3, 5'h06}) : {3'h3, 5'h05};
            CTU_SHORT_RELATIVE_JUMP: c = {3'h2, 5'h04};
            CTU_INDIRECT_TABLE_JUMP: c = {3'h1, 5'h05};
            CTU_ABSOLUTE_CALL: c = {3'h2, 5'h09};
            CTU_EXTENDED_CALL:
                c = form[0] ? (src ? {3'h2, 5'h0d} : {3'h3, 5'h0e}) : (src ? {3'h4, 5'h0d} : {3'h5, 5'h0e});
            CTU_LONG_CALL:
                c = form[0] ? (src ? {3'h2, 5'h09} : {3'h3, 5'h0a}) : {3'h3, 5'h09};
            CTU_SUBROUTINE_RETURN, CTU_INTERRUPT_RETURN: c = {3'h1, 5'h07};
            CTU_EXTENDED_RETURN: c = src ? {3'h2, 5'h08} : {3'h3, 5'h09};
            CTU_TRAP: c = src ? {3'h1, 5'h0b} : {3'h2, 5'h0c};
            default: c = {3'h1, 5'h01};
        endcase
        return c;
    endfunction : ctu_base_cost

    // ----------------------------------------
    // state
    // ----------------------------------------
    ctu_state_type st_q;
    ctu_instr_type instr_q;
    ctu_status_type stat_q;
    logic [2:0] ctrl_q;
    logic [23:0] opnd_q;
    logic [24:0] data_q;
    logic [15:0] data_pointer_q;
    logic [23:0] pc_q;
    logic [7:0] second_status_word_q;
    logic [7:0] sp_q;
    logic [7:0] stk [CTU_STACK_BYTES];
    logic wpend_q;
    logic rpend_q;
    logic [7:0] addr_q;
    logic wr_ok;
    logic instr_wr;
    logic exec;

    // ----------------------------------------
    // bus slave
    // ----------------------------------------
    assign instr_wr = wpend_q && (addr_q == CTU_INSTR_OFS);
    // an instruction write holds the bus until its effects are in the registers
    assign hreadyout = !(instr_wr && (st_q != CTU_ST_DONE));
    assign hresp = 1'b0;
    assign wr_ok = wpend_q && hreadyout;
    assign exec = (st_q == CTU_ST_EXEC);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wpend_q <= 1'b0;
            rpend_q <= 1'b0;
            addr_q <= 8'h00;
        end else if (hready) begin
            wpend_q <= hsel && htrans[1] && hwrite;
            rpend_q <= hsel && htrans[1] && !hwrite;
            addr_q <= {haddr[7:2], 2'b00};
        end
    end

    always_comb begin
        hrdata = 32'h0;
        if (rpend_q) begin
            unique case (addr_q)
                CTU_CTRL_OFS: hrdata = {29'h0, ctrl_q};
                CTU_INSTR_OFS: hrdata = {22'h0, instr_q};
                CTU_OPND_OFS: hrdata = {8'h0, opnd_q};
                CTU_DATA_OFS: hrdata = {7'h0, data_q};
                CTU_DATA_POINTER_OFS: hrdata = {16'h0, data_pointer_q};
                CTU_PC_OFS: hrdata = {8'h0, pc_q};
                CTU_SECOND_STATUS_WORD_OFS: hrdata = {24'h0, second_status_word_q};
                CTU_STATUS_OFS: hrdata = stat_q;
                CTU_SP_OFS: hrdata = {24'h0, sp_q};
                default: hrdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= CTU_ST_IDLE;
            instr_q <= '0;
        end else begin
            unique case (st_q)
                CTU_ST_IDLE: begin
                    if (instr_wr) begin
                        instr_q <= hwdata[9:0];
                        st_q <= CTU_ST_EXEC;
                    end
                end
                CTU_ST_EXEC: st_q <= CTU_ST_DONE;
                CTU_ST_DONE: st_q <= CTU_ST_IDLE;
                default: st_q <= CTU_ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= CTU_CTRL_RST;
            opnd_q <= 24'h0;
            data_pointer_q <= 16'h0;
        end else if (wr_ok) begin
            if (addr_q == CTU_CTRL_OFS) begin
                ctrl_q <= hwdata[2:0];
            end
            if (addr_q == CTU_OPND_OFS) begin
                opnd_q <= hwdata[23:0];
            end
            if (addr_q == CTU_DATA_POINTER_OFS) begin
                data_pointer_q <= hwdata[15:0];
            end
        end
    end

    // ----------------------------------------
    // execution
    // ----------------------------------------
    logic src;
    logic frame24;
    logic bitv;
    logic [7:0] acc;
    logic [7:0] opa;
    logic [7:0] opb;
    ctu_cost_type cost;
    logic [23:0] pc_adv;
    logic [23:0] npc;
    logic cond;
    logic taken;
    logic odd_ok;
    logic carry_n;
    logic clr_n;
    logic [4:0] add_n;
    logic [7:0] dec_n;
    logic [7:0] second_status_word_n;
    logic [3:0][7:0] pb;
    logic [2:0] pn;
    logic [2:0] pp;
    ctu_instr_type iq;

    assign src = ctrl_q[CTU_CTRL_SRC];
    assign frame24 = ctrl_q[CTU_CTRL_FRAME];
    assign acc = data_q[7:0];
    assign opa = data_q[15:8];
    assign opb = data_q[23:16];
    assign bitv = data_q[CTU_DATA_BIT];
    assign iq = instr_q;

    always_comb begin
        cost = ctu_base_cost(iq.op, iq.form, src);
        pc_adv = pc_q + {21'h0, cost.len};
        npc = pc_adv;
        dec_n = opa - 8'h01;
        cond = 1'b0;
        taken = 1'b0;
        odd_ok = 1'b1;
        carry_n = stat_q.carry;
        clr_n = 1'b0;
        add_n = 5'h00;
        second_status_word_n = second_status_word_q;
        pb = '0;
        pn = 3'h0;
        pp = 3'h0;
        unique case (iq.op)
            CTU_NO_OPERATION: odd_ok = 1'b0;
            CTU_BRANCH_ON_BIT_SET: begin
                cond = 1'b1;
                taken = bitv;
                add_n = ctu_opd_add(iq.kind, CTU_TEST_PORT_ADD, CTU_TEST_PSFR_ADD);
            end
            CTU_BRANCH_ON_BIT_CLEAR: begin
                cond = 1'b1;
                taken = !bitv;
                add_n = ctu_opd_add(iq.kind, CTU_TEST_PORT_ADD, CTU_TEST_PSFR_ADD);
            end
            CTU_BRANCH_ON_BIT_SET_THEN_CLEAR: begin
                cond = 1'b1;
                taken = bitv;
                clr_n = bitv;
                add_n = ctu_opd_add(iq.kind, CTU_CLR_PORT_ADD, CTU_CLR_PSFR_ADD);
            end
            CTU_BRANCH_ON_ACC_ZERO: begin
                cond = 1'b1;
                taken = (acc == 8'h00);
            end
            CTU_BRANCH_ON_ACC_NONZERO: begin
                cond = 1'b1;
                taken = (acc != 8'h00);
            end
            CTU_COMPARE_BRANCH_UNEQUAL: begin
                cond = 1'b1;
                carry_n = (opa < opb);
                taken = (opa != opb);
                // only the direct-address form can reach a port or peripheral
                if (iq.form == 2'h0) begin
                    add_n = ctu_opd_add(iq.kind, CTU_TEST_PORT_ADD, CTU_TEST_PSFR_ADD);
                end
            end
            CTU_DECREMENT_BRANCH_NONZERO: begin
                cond = 1'b1;
                taken = (dec_n != 8'h00);
                if (iq.form[0]) begin
                    add_n = ctu_opd_add(iq.kind, CTU_DEC_PORT_ADD, CTU_DEC_PSFR_ADD);
                end
            end
            CTU_ABSOLUTE_JUMP: begin
                npc = {pc_adv[23:11], opnd_q[10:0]};
                add_n = iq.ext ? CTU_EXT_SHORT_ADD : 5'h00;
            end
            CTU_EXTENDED_JUMP: begin
                npc = opnd_q;
                add_n = iq.ext ? CTU_EXT_LONG_ADD : 5'h00;
            end
            CTU_LONG_JUMP: begin
                npc = {pc_adv[23:16], opnd_q[15:0]};
                add_n = iq.ext ? CTU_EXT_LONG_ADD : 5'h00;
            end
            CTU_SHORT_RELATIVE_JUMP: begin
                npc = pc_adv + {{16{opnd_q[7]}}, opnd_q[7:0]};
                add_n = iq.ext ? CTU_EXT_LONG_ADD : 5'h00;
            end
            CTU_INDIRECT_TABLE_JUMP: begin
                npc = {8'hff, {8'h00, acc} + data_pointer_q};
                add_n = iq.ext ? CTU_EXT_LONG_ADD : 5'h00;
            end
            CTU_ABSOLUTE_CALL: begin
                pb = {16'h0, pc_adv[15:8], pc_adv[7:0]};
                pn = 3'h2;
                npc = {pc_adv[23:11], opnd_q[10:0]};
                add_n = iq.ext ? CTU_EXT_SHORT_ADD : 5'h00;
            end
            CTU_EXTENDED_CALL: begin
                pb = {8'h0, pc_adv};
                pn = 3'h3;
                npc = opnd_q;
                add_n = iq.ext ? CTU_EXT_SHORT_ADD : 5'h00;
            end
            CTU_LONG_CALL: begin
                pb = {16'h0, pc_adv[15:0]};
                pn = 3'h2;
                npc = {pc_adv[23:16], opnd_q[15:0]};
                add_n = iq.ext ? CTU_EXT_SHORT_ADD : 5'h00;
            end
            CTU_SUBROUTINE_RETURN: begin
                npc = {pc_q[23:16], stk[sp_q], stk[sp_q - 8'h01]};
                pp = 3'h2;
            end
            CTU_EXTENDED_RETURN: begin
                npc = {stk[sp_q], stk[sp_q - 8'h01], stk[sp_q - 8'h02]};
                pp = 3'h3;
            end
            CTU_INTERRUPT_RETURN: begin
                if (frame24) begin
                    npc = {stk[sp_q], stk[sp_q - 8'h01], stk[sp_q - 8'h02]};
                    second_status_word_n = stk[sp_q - 8'h03];
                    pp = 3'h4;
                    add_n = CTU_FRAME_ADD;
                end else begin
                    npc = {pc_q[23:16], stk[sp_q], stk[sp_q - 8'h01]};
                    pp = 3'h2;
                end
            end
            CTU_TRAP: begin
                odd_ok = 1'b0;
                npc = TRAP_VECTOR;
                if (frame24) begin
                    pb = {pc_adv, second_status_word_q};
                    pn = 3'h4;
                    add_n = CTU_FRAME_ADD;
                end else begin
                    pb = {16'h0, pc_adv[15:0]};
                    pn = 3'h2;
                end
            end
            default: odd_ok = 1'b0;
        endcase
        if (cond) begin
            odd_ok = taken;
            if (taken) begin
                npc = pc_adv + {{16{opnd_q[7]}}, opnd_q[7:0]};
                add_n = add_n + CTU_TAKEN_ADD;
            end
        end
        // odd-target penalty needs internal execution and an internal target
        if (odd_ok && ctrl_q[CTU_CTRL_INTEXE] && !iq.ext && npc[0]) begin
            add_n = add_n + CTU_ODD_ADD;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pc_q <= CTU_PC_RST;
            sp_q <= CTU_SP_RST;
            second_status_word_q <= 8'h00;
            data_q <= 25'h0;
            stat_q <= '0;
        end else if (exec) begin
            pc_q <= npc;
            sp_q <= sp_q + {5'h0, pn} - {5'h0, pp};
            second_status_word_q <= second_status_word_n;
            if (clr_n) begin
                data_q[CTU_DATA_BIT] <= 1'b0;
            end
            if (iq.op == CTU_DECREMENT_BRANCH_NONZERO) begin
                data_q[15:8] <= dec_n;
            end
            stat_q <= '{dec: dec_n, zero: 13'h0, clr: clr_n, carry: carry_n, taken: cond && taken,
                        len: cost.len, states: cost.states + add_n};
        end else if (wr_ok) begin
            if (addr_q == CTU_PC_OFS) begin
                pc_q <= hwdata[23:0];
            end
            if (addr_q == CTU_SP_OFS) begin
                sp_q <= hwdata[7:0];
            end
            if (addr_q == CTU_SECOND_STATUS_WORD_OFS) begin
                second_status_word_q <= hwdata[7:0];
            end
            if (addr_q == CTU_DATA_OFS) begin
                data_q <= hwdata[24:0];
            end
        end
    end

    // stack bytes grow upward; the lowest pushed byte sits just above the old top
    always_ff @(posedge hclk) begin
        if (exec) begin
            for (int i = 0; i < 4; i++) begin
                if (3'(i) < pn) begin
                    stk[sp_q + 8'(i + 1)] <= pb[i];
                end
            end
        end
    end

endmodule : ctu_control_transfer

/* File: verif/ctu_control_transfer_chk.sv */
`timescale 1ns/1ps
module ctu_control_transfer_chk
    import ctu_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata
);
    // ----------------------------------------
    // data-phase tracking
    // ----------------------------------------
    logic tk;
    logic rd_q;
    logic wi_q;
    logic nop_q;
    logic [7:0] a_q;
    assign tk = hsel && htrans[1] && hready;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_q <= 1'b0;
            wi_q <= 1'b0;
            nop_q <= 1'b0;
            a_q <= 8'h00;
        end else if (hready) begin
            rd_q <= tk && !hwrite;
            wi_q <= tk && hwrite && haddr[7:0] == CTU_INSTR_OFS;
            if (tk) a_q <= haddr[7:0];
            if (wi_q) nop_q <= hwdata[4:0] == 5'h00;
        end
    end
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_two_waits;
        !hreadyout [*2] ##1 hreadyout;
    endsequence
    a_resp_okay: assert property (hresp == 1'b0) else $error("bad response");
    a_instr_wait: assert property (tk && hwrite && haddr[7:0] == CTU_INSTR_OFS |=> s_two_waits)
        else $error("exec wait wrong");
    a_read_fast: assert property (tk && !hwrite |=> hreadyout) else $error("read stalled");
    a_write_fast: assert property (tk && hwrite && haddr[7:0] != CTU_INSTR_OFS |=> hreadyout)
        else $error("write stalled");
    a_rdata_idle: assert property (!rd_q |-> hrdata == 32'h0) else $error("rdata not idle");
    a_ctrl_upper: assert property (rd_q && a_q == CTU_CTRL_OFS |-> hrdata[31:3] == 29'h0)
        else $error("ctrl upper bits");
    a_status_gap: assert property (rd_q && a_q == CTU_STATUS_OFS |-> hrdata[23:11] == 13'h0)
        else $error("status gap bits");
    a_nop_cost: assert property (rd_q && a_q == CTU_STATUS_OFS && nop_q |-> hrdata[8:0] == 9'h021)
        else $error("nop cost wrong");
endmodule : ctu_control_transfer_chk

bind ctu_control_transfer ctu_control_transfer_chk ctu_control_transfer_chk_inst (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));

/* File: verif/ctu_bus_fabric.sv */
`timescale 1ns/1ps
// ----------------------------------------
// one-slave fabric: the slave's readyout is the bus ready
// ----------------------------------------
module ctu_bus_fabric (
    // slave side
    input wire logic hreadyout,
    // master side
    output logic hready
);
    assign hready = hreadyout;
endmodule : ctu_bus_fabric

/* File: verif/testbench.sv */
`timescale 1ns/1ps
module testbench;
    import ctu_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b1;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic [31:0] rv;
    logic hready;
    logic hreadyout;
    logic hresp;
    int err_total = 0;
    int n_compared = 0;
    always #20 hclk = ~hclk;
    ctu_control_transfer ctu_control_transfer_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
    ctu_bus_fabric ctu_bus_fabric_inst (.hreadyout(hreadyout), .hready(hready));
    // ----------------------------------------
    // bus tasks
    // ----------------------------------------
    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : tally_and_finish
    // bounded: a stuck readyout must not hang the run
    task automatic wt;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 20);
        if (n >= 20) begin
            err_total++;
            tally_and_finish;
        end
    endtask : wt
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] v);
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        wt;
        htrans <= 2'h0;
        hwdata <= d;
        wt;
        v = hrdata;
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, rv);
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0, rv);
        n_compared++;
        if (rv !== e) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, rv, e);
        end
    endtask : rdc
    task automatic run(input logic [2:0] c, input logic [23:0] p, input logic [31:0] d, input logic [23:0] o,
        input logic [9:0] i, input logic [23:0] ep, input logic [10:0] es);
        wr(CTU_CTRL_OFS, {29'h0, c});
        wr(CTU_PC_OFS, {8'h0, p});
        wr(CTU_DATA_OFS, d);
        wr(CTU_OPND_OFS, {8'h0, o});
        wr(CTU_INSTR_OFS, {22'h0, i});
        rdc(CTU_PC_OFS, {8'h0, ep});
        xfer(1'b0, CTU_STATUS_OFS, 32'h0, rv);
        rv[31:11] = 21'h0;
        n_compared++;
        if (rv[10:0] !== es) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, rv[10:0], es);
        end
        $display("test op %h done", i[4:0]);
    endtask : run
    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdc(CTU_CTRL_OFS, 32'h4);
        rdc(CTU_PC_OFS, 32'hff0000);
        rdc(CTU_SP_OFS, 32'h7);
        wr(8'h3c, 32'hffffffff);
        rdc(8'h3c, 32'h0);
        wr(CTU_DATA_POINTER_OFS, 32'h1000);
        run(3'h4, 24'h1000, 32'h01000000, 24'h10, 10'h001, 24'h1013, 11'h166);
        run(3'h4, 24'h1000, 32'h01000000, 24'h10, 10'h002, 24'h1003, 11'h062);
        run(3'h4, 24'h1000, 32'h01000000, 24'h11, 10'h003, 24'h1014, 11'h567);
        rdc(CTU_DATA_OFS, 32'h0);
        run(3'h4, 24'h1000, 32'h01000000, 24'h10, 10'h081, 24'h1013, 11'h167);
        run(3'h4, 24'h1000, 32'h01000000, 24'h11, 10'h103, 24'h1014, 11'h56c);
        run(3'h4, 24'h1000, 32'h0, 24'h20, 10'h004, 24'h1022, 11'h145);
        run(3'h4, 24'h1000, 32'h0, 24'h20, 10'h005, 24'h1002, 11'h042);
        run(3'h4, 24'h1000, 32'h00201000, 24'h10, 10'h046, 24'h1013, 11'h366);
        run(3'h5, 24'h1000, 32'h00201000, 24'h10, 10'h046, 24'h1014, 11'h386);
        run(3'h4, 24'h1000, 32'h00102000, 24'h10, 10'h046, 24'h1013, 11'h166);
        run(3'h4, 24'h1000, 32'h100, 24'h10, 10'h007, 24'h1002, 11'h042);
        run(3'h4, 24'h1000, 32'h200, 24'h10, 10'h007, 24'h1012, 11'h145);
        rdc(CTU_DATA_OFS, 32'h100);
        run(3'h4, 24'h1000, 32'h200, 24'h10, 10'h0a7, 24'h1013, 11'h169);
        run(3'h4, 24'h1000, 32'h0, 24'h2345, 10'h00a, 24'h2345, 11'h066);
        run(3'h4, 24'h1000, 32'h0, 24'h2345, 10'h20a, 24'h2345, 11'h068);
        run(3'h4, 24'h1000, 32'h10, 24'h0, 10'h00c, 24'hff1010, 11'h025);
        run(3'h4, 24'h1000, 32'h0, 24'hfe, 10'h00b, 24'h1000, 11'h044);
        run(3'h4, 24'h1000, 32'h0, 24'h0, 10'h000, 24'h1001, 11'h021);
        run(3'h4, 24'h1000, 32'h0, 24'h123456, 10'h009, 24'h123456, 11'h0a6);
        run(3'h4, 24'h1000, 32'h0, 24'h123, 10'h208, 24'h1123, 11'h045);
        run(3'h4, 24'h1000, 32'h0, 24'h2000, 10'h00f, 24'h2000, 11'h069);
        rdc(CTU_SP_OFS, 32'h9);
        run(3'h4, 24'h2000, 32'h0, 24'h0, 10'h010, 24'h1003, 11'h028);
        run(3'h4, 24'h1000, 32'h0, 24'h200000, 10'h00e, 24'h200000, 11'h0ae);
        rdc(CTU_SP_OFS, 32'ha);
        run(3'h4, 24'h200000, 32'h0, 24'h0, 10'h011, 24'h1005, 11'h06a);
        run(3'h5, 24'h1000, 32'h0, 24'h200000, 10'h00e, 24'h200000, 11'h08d);
        run(3'h5, 24'h200000, 32'h0, 24'h0, 10'h011, 24'h1004, 11'h048);
        run(3'h4, 24'h1000, 32'h0, 24'h0, 10'h013, 24'hff0080, 11'h04c);
        run(3'h4, 24'hff0080, 32'h0, 24'h0, 10'h012, 24'hff1002, 11'h027);
        wr(CTU_SECOND_STATUS_WORD_OFS, 32'h5a);
        run(3'h6, 24'h1000, 32'h0, 24'h0, 10'h013, 24'hff0080, 11'h051);
        wr(CTU_SECOND_STATUS_WORD_OFS, 32'h0);
        run(3'h6, 24'hff0080, 32'h0, 24'h0, 10'h012, 24'h1002, 11'h02c);
        rdc(CTU_SECOND_STATUS_WORD_OFS, 32'h5a);
        rdc(CTU_SP_OFS, 32'h7);
        tally_and_finish;
    end
endmodule : testbench
